/* File: misc_regs.sv */
// Interrupt mask and sense, coin charger and buck one registers behind an AHB-Lite slave.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
module misc_regs (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event sources.
  input wire logic powerup_in_progress,
  input wire logic powerdown_in_progress,
  input wire logic power_button_input,
  input wire logic low_rail_level,
  input wire logic rail_overvolt_level,
  // Fuse preload values.
  input wire logic [5:0] fuse_run_code,
  input wire logic fuse_run_enable,
  // Current power mode.
  input wire pmic_regs_pkg::power_mode_t power_mode,
  // Interrupt pin, open drain.
  output logic irq_out_n,
  output logic irq_oe_n,
  // Regulator controls.
  output logic [3:0] coin_charge_voltage,
  output logic coin_charge_enable,
  output logic [5:0] buck_one_code,
  output logic buck_one_run_enable
);
  import pmic_regs_pkg::*;

  // Turns a byte address into a register index; an address above 0x3ff or not word aligned gives IDX_NONE.
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[31:10] != 22'h000000 || addr[1:0] != 2'h0) begin
      idx = IDX_NONE;
    end
    return idx;
  endfunction : reg_index

  logic [4:0] mask_q, mask_d;
  logic [4:0] flag_q, flag_d;
  logic [4:0] sense_q, sense_d;
  logic [3:0] coin_volt_q, coin_volt_d;
  logic coin_en_q, coin_en_d;
  logic [5:0] run_q, run_d;
  logic [5:0] stby_q, stby_d;
  logic [5:0] slp_q, slp_d;
  logic run_en_q, run_en_d;
  logic load_q, load_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic irq_n_q, irq_n_d;
  logic [5:0] code_q, code_d;
  logic ready_q, ready_d;
  logic resp_q, resp_d;
  logic addr_phase;
  logic [7:0] cur_idx;
  logic [7:0] wdata;
  logic [4:0] events;
  logic [4:0] write_clear;
  logic [4:0] read_clear;
  logic [4:0] level_in;

  always_comb begin
    addr_phase = hsel && htrans[1] && hready;
    cur_idx = reg_index(haddr);
    wdata = hwdata[7:0];
    wr_pend_d = addr_phase && hwrite && (cur_idx != IDX_NONE);
    wr_idx_d = wr_pend_d ? cur_idx : IDX_NONE;
    load_d = 1'b0;

    level_in = {rail_overvolt_level, low_rail_level, power_button_input,
                powerdown_in_progress, powerup_in_progress};
    sense_d = level_in;
    // The sense bits follow their sources only; bus writes never reach them.

    // Completion is the end of a transition; rail events fire on entering the fault band.
    events[POS_POWERUP] = sense_q[POS_POWERUP] && !powerup_in_progress;
    events[POS_POWERDOWN] = sense_q[POS_POWERDOWN] && !powerdown_in_progress;
    events[POS_BUTTON] = sense_q[POS_BUTTON] != power_button_input;
    events[POS_LOW_RAIL] = !sense_q[POS_LOW_RAIL] && low_rail_level;
    events[POS_OVERVOLT] = !sense_q[POS_OVERVOLT] && rail_overvolt_level;

    write_clear = 5'h00;
    if (wr_pend_q && wr_idx_q == IDX_MISC_IRQ_STATUS) begin
      write_clear = wdata[4:0];
    end
    read_clear = 5'h00;
    if (addr_phase && !hwrite && cur_idx == IDX_MISC_IRQ_STATUS) begin
      read_clear = 5'h1f;
    end
    // A new event wins over a clear in the same cycle, so none is lost.
    flag_d = (flag_q & ~(write_clear | read_clear)) | events;

    mask_d = mask_q;
    coin_volt_d = coin_volt_q;
    coin_en_d = coin_en_q;
    run_d = run_q;
    stby_d = stby_q;
    slp_d = slp_q;
    run_en_d = run_en_q;
    if (load_q) begin
      run_d = fuse_run_code;
      stby_d = fuse_run_code;
      slp_d = fuse_run_code;
      run_en_d = fuse_run_enable;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        IDX_MISC_IRQ_MASK: mask_d = wdata[4:0];
        IDX_COIN_CHARGER_CONTROL: begin
          coin_volt_d = wdata[COIN_VOLT_LSB +: COIN_VOLT_WIDTH];
          coin_en_d = wdata[COIN_ENABLE_POS];
        end
        IDX_BUCK_ONE_RUN_VOLTAGE: run_d = wdata[BUCK_CODE_LSB +: BUCK_CODE_WIDTH];
        IDX_BUCK_ONE_STANDBY_VOLTAGE: stby_d = wdata[BUCK_CODE_LSB +: BUCK_CODE_WIDTH];
        IDX_BUCK_ONE_SLEEP_VOLTAGE: slp_d = wdata[BUCK_CODE_LSB +: BUCK_CODE_WIDTH];
        IDX_BUCK_ONE_CONTROL: run_en_d = wdata[BUCK_RUN_ENABLE_POS];
        default: mask_d = mask_q;
      endcase
    end

    // Read data is built from the next values, and status from the flags less a pending write clear, so that a write in its data phase is seen at once.
    hrdata_d = 32'h00000000;
    if (addr_phase && !hwrite) begin
      case (cur_idx)
        IDX_MISC_IRQ_STATUS: hrdata_d[4:0] = flag_q & ~write_clear;
        IDX_MISC_IRQ_MASK: hrdata_d[4:0] = mask_d;
        IDX_MISC_IRQ_SENSE: hrdata_d[4:0] = sense_d;
        IDX_COIN_CHARGER_CONTROL: hrdata_d[4:0] = {coin_en_d, coin_volt_d};
        IDX_BUCK_ONE_RUN_VOLTAGE: hrdata_d[5:0] = run_d;
        IDX_BUCK_ONE_STANDBY_VOLTAGE: hrdata_d[5:0] = stby_d;
        IDX_BUCK_ONE_SLEEP_VOLTAGE: hrdata_d[5:0] = slp_d;
        IDX_BUCK_ONE_CONTROL: hrdata_d[0] = run_en_d;
        default: hrdata_d = 32'h00000000;
      endcase
    end

    // Bus answers are registered like every other output; the slave has no wait state.
    ready_d = 1'b1;
    resp_d = 1'b0;

    irq_n_d = ~|(flag_d & ~mask_d);

    case (power_mode)
      MODE_RUN: code_d = run_d;
      MODE_STANDBY: code_d = stby_d;
      MODE_SLEEP: code_d = slp_d;
      default: code_d = run_d;
    endcase
  end

  // The mask comes up masked even before the clock runs; the interrupt pin comes from irq_n_q, which reset sets high only at a clock edge.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask_q <= MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_q <= STATUS_RESET;
      sense_q <= SENSE_RESET;
      coin_volt_q <= COIN_VOLT_RESET;
      coin_en_q <= COIN_ENABLE_RESET;
      run_q <= BUCK_CODE_RESET;
      stby_q <= BUCK_CODE_RESET;
      slp_q <= BUCK_CODE_RESET;
      run_en_q <= BUCK_RUN_ENABLE_RESET;
      load_q <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_idx_q <= IDX_NONE;
      hrdata_q <= 32'h00000000;
      irq_n_q <= 1'b1;
      code_q <= BUCK_CODE_RESET;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      sense_q <= sense_d;
      coin_volt_q <= coin_volt_d;
      coin_en_q <= coin_en_d;
      run_q <= run_d;
      stby_q <= stby_d;
      slp_q <= slp_d;
      run_en_q <= run_en_d;
      load_q <= load_d;
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      irq_n_q <= irq_n_d;
      code_q <= code_d;
      ready_q <= ready_d;
      resp_q <= resp_d;
    end
  end

  // The slave never stretches a transfer and never reports an error.
  assign hrdata = hrdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;

  assign irq_out_n = irq_n_q;
  assign irq_oe_n = irq_n_q;
  assign coin_charge_voltage = coin_volt_q;
  assign coin_charge_enable = coin_en_q;
  assign buck_one_code = code_q;
  assign buck_one_run_enable = run_en_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence status_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_MISC_IRQ_STATUS
      ##1 hwdata[POS_BUTTON] && !events[POS_BUTTON];
  endsequence

  sequence status_read_s;
    hsel && htrans[1] && hready && !hwrite && reg_index(haddr) == IDX_MISC_IRQ_STATUS
      && !events[POS_LOW_RAIL];
  endsequence

  sequence powerup_done_s;
    powerup_in_progress ##1 !powerup_in_progress;
  endsequence

  sequence powerdown_done_s;
    powerdown_in_progress ##1 !powerdown_in_progress;
  endsequence

  sequence button_rise_s;
    !power_button_input ##1 power_button_input;
  endsequence

  sequence low_rise_s;
    !low_rail_level ##1 low_rail_level;
  endsequence

  sequence over_rise_s;
    !rail_overvolt_level ##1 rail_overvolt_level;
  endsequence

  // Each write sequence ends at the edge that closes the data phase.
  sequence mask_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_MISC_IRQ_MASK ##1 1'b1;
  endsequence

  sequence sense_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_MISC_IRQ_SENSE ##1 1'b1;
  endsequence

  sequence coin_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_COIN_CHARGER_CONTROL
      ##1 1'b1;
  endsequence

  sequence run_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_BUCK_ONE_RUN_VOLTAGE
      ##1 1'b1;
  endsequence

  sequence stby_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_BUCK_ONE_STANDBY_VOLTAGE
      ##1 1'b1;
  endsequence

  sequence slp_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_BUCK_ONE_SLEEP_VOLTAGE
      ##1 1'b1;
  endsequence

  sequence ctrl_write_s;
    hsel && htrans[1] && hready && hwrite && reg_index(haddr) == IDX_BUCK_ONE_CONTROL
      ##1 1'b1;
  endsequence

  irq_unmasked_a: assert property (|(flag_q & ~mask_q) |-> !irq_out_n && !irq_oe_n)
    else $error("interrupt not driven for an unmasked flag");
  irq_masked_a: assert property (!(|(flag_q & ~mask_q)) |-> irq_out_n)
    else $error("interrupt driven with all flags masked or clear");
  mask_reset_a: assert property ($fell(reset) |-> mask_q == MASK_RESET)
    else $error("mask not all set after reset");
  powerup_mask_a: assert property ($fell(reset) |-> mask_q[POS_POWERUP])
    else $error("power-up mask bit not set by reset");
  sense_power_a: assert property (1'b1 |=> sense_q[1:0] == $past(level_in[1:0]))
    else $error("transition sense does not follow its source");
  sense_down_a: assert property ($rose(powerdown_in_progress) |=> sense_q[POS_POWERDOWN])
    else $error("power-down sense missed transition");
  sense_button_a: assert property (1'b1 |=> sense_q[POS_BUTTON] == $past(power_button_input))
    else $error("button sense does not follow input");
  sense_low_a: assert property (low_rail_level [*2] |-> sense_q[POS_LOW_RAIL])
    else $error("low rail sense not set");
  sense_over_a: assert property (!rail_overvolt_level [*2] |-> !sense_q[POS_OVERVOLT])
    else $error("overvoltage sense stuck high");
  sense_clean_a: assert property ($fell(reset) |-> sense_q == SENSE_RESET)
    else $error("sense register not zero after reset");
  coin_reset_a: assert property ($fell(reset) |-> coin_volt_q == COIN_VOLT_RESET)
    else $error("coin voltage not at reset code");
  coin_enable_a: assert property ($fell(reset) |-> !coin_en_q ##1 !coin_en_q)
    else $error("coin charger enabled after reset");
  fuse_run_a: assert property ($fell(reset) |=> run_q == $past(fuse_run_code))
    else $error("run code not loaded from fuses");
  fuse_stby_a: assert property ($fell(reset) |=> stby_q == run_q)
    else $error("standby code differs from run code after load");
  fuse_slp_a: assert property ($fell(reset) |=> slp_q == run_q)
    else $error("sleep code differs from run code after load");
  fuse_en_a: assert property ($fell(reset) |=> run_en_q == $past(fuse_run_enable))
    else $error("run enable not loaded from fuses");
  clear_write_a: assert property (status_write_s |=> !flag_q[POS_BUTTON])
    else $error("write one did not clear status");
  clear_read_a: assert property (status_read_s |=> !flag_q[POS_LOW_RAIL])
    else $error("read did not clear status");
  powerup_flag_a: assert property (powerup_done_s |=> flag_q[POS_POWERUP])
    else $error("power-up completion did not set status");
  irq_or_a: assert property (1'b1 |-> irq_out_n == !(|(flag_q & ~mask_q)))
    else $error("interrupt differs from OR of unmasked flags");
  code_sel_a: assert property (power_mode == MODE_SLEEP |=> buck_one_code == slp_q)
    else $error("sleep mode did not select sleep code");
  code_run_a: assert property (power_mode == MODE_RUN |=> buck_one_code == run_q)
    else $error("run mode did not select run code");
  code_stby_a: assert property (power_mode == MODE_STANDBY |=> buck_one_code == stby_q)
    else $error("standby mode did not select standby code");
  irq_pin_a: assert property (1'b1 |-> irq_oe_n == irq_out_n)
    else $error("pin enable differs from interrupt level");
  down_flag_a: assert property (powerdown_done_s |=> flag_q[POS_POWERDOWN])
    else $error("power-down completion did not set status");
  button_flag_a: assert property (button_rise_s |=> flag_q[POS_BUTTON])
    else $error("button change did not set status");
  low_flag_a: assert property (low_rise_s |=> flag_q[POS_LOW_RAIL])
    else $error("low rail entry did not set status");
  over_flag_a: assert property (over_rise_s |=> flag_q[POS_OVERVOLT])
    else $error("overvoltage entry did not set status");
  mask_write_a: assert property (mask_write_s |=> mask_q == $past(hwdata[4:0]))
    else $error("mask write did not land");
  sense_write_a: assert property (sense_write_s |=> sense_q == $past(level_in))
    else $error("sense register changed by a write");
  coin_volt_a: assert property (coin_write_s |=> coin_volt_q == $past(hwdata[3:0]))
    else $error("coin voltage write did not land");
  coin_en_a: assert property (coin_write_s |=> coin_en_q == $past(hwdata[4]))
    else $error("coin enable write did not land");
  run_write_a: assert property (run_write_s |=> run_q == $past(hwdata[5:0]))
    else $error("run code write did not land");
  stby_write_a: assert property (stby_write_s |=> stby_q == $past(hwdata[5:0]))
    else $error("standby code write did not land");
  slp_write_a: assert property (slp_write_s |=> slp_q == $past(hwdata[5:0]))
    else $error("sleep code write did not land");
  enable_write_a: assert property (ctrl_write_s |=> run_en_q == $past(hwdata[0]))
    else $error("run enable write did not land");
  bus_okay_a: assert property (1'b1 |-> hreadyout && !hresp)
    else $error("slave stretched a transfer or reported an error");
  read_idle_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
    else $error("read data stands without a read");

endmodule : misc_regs

/* File: pmic_regs_pkg.sv */
// Register map, field layout and reset values of the interrupt, coin charger and buck one bank.
package pmic_regs_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] IDX_MISC_IRQ_STATUS = 8'h28;
  localparam logic [7:0] IDX_MISC_IRQ_MASK = 8'h29;
  localparam logic [7:0] IDX_MISC_IRQ_SENSE = 8'h2a;
  localparam logic [7:0] IDX_COIN_CHARGER_CONTROL = 8'h30;
  localparam logic [7:0] IDX_BUCK_ONE_RUN_VOLTAGE = 8'h32;
  localparam logic [7:0] IDX_BUCK_ONE_STANDBY_VOLTAGE = 8'h33;
  localparam logic [7:0] IDX_BUCK_ONE_SLEEP_VOLTAGE = 8'h34;
  localparam logic [7:0] IDX_BUCK_ONE_CONTROL = 8'h35;
  localparam logic [7:0] IDX_NONE = 8'hff;

  // Event bit positions, shared by the status, mask and sense registers.
  localparam int EVENT_COUNT = 5;
  localparam int POS_POWERUP = 0;
  localparam int POS_POWERDOWN = 1;
  localparam int POS_BUTTON = 2;
  localparam int POS_LOW_RAIL = 3;
  localparam int POS_OVERVOLT = 4;

  // Field layout of the charger and buck registers.
  localparam int COIN_VOLT_LSB = 0;
  localparam int COIN_VOLT_WIDTH = 4;
  localparam int COIN_ENABLE_POS = 4;
  localparam int BUCK_CODE_LSB = 0;
  localparam int BUCK_CODE_WIDTH = 6;
  localparam int BUCK_RUN_ENABLE_POS = 0;

  // Reset values.
  localparam logic [4:0] MASK_RESET = 5'h1f;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] SENSE_RESET = 5'h00;
  localparam logic [3:0] COIN_VOLT_RESET = 4'h0;
  localparam logic COIN_ENABLE_RESET = 1'b0;
  localparam logic [5:0] BUCK_CODE_RESET = 6'h00;
  localparam logic BUCK_RUN_ENABLE_RESET = 1'b0;

  // Power modes that pick the buck one voltage code.
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STANDBY,
    MODE_SLEEP
  } power_mode_t;

endpackage : pmic_regs_pkg

/* File: host_bus.sv */
// Host side model: an AHB-Lite master and the pulled-up interrupt pin.
`timescale 1ns/10ps
module host_bus (
  // Clock.
  input wire logic mclk,
  // AHB-Lite master.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Interrupt pin as the host sees it.
  input wire logic irq_oe_n,
  output logic irq_pin
);
  // The pin has a pull-up, so it reads high whenever the device lets go of it.
  assign irq_pin = irq_oe_n ? 1'b1 : 1'b0;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; the wait is left to the bench timeout.
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : xfer
endmodule : host_bus

/* File: tb_top.sv */
// Self-checking bench for the interrupt, coin charger and buck one registers.
`timescale 1ns/10ps
module tb_top;
  import pmic_regs_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, irq_out_n, irq_oe_n, irq_pin, fuse_en, cen, ben;
  logic [31:0] haddr, hwdata, hrdata, rd, rng;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] lvl, r5;
  logic [5:0] fuse_code, bcode;
  logic [3:0] cvolt;
  logic [5:0] codes [3];
  logic [7:0] bidx [3];
  power_mode_t power_mode;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  host_bus host (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .irq_oe_n(irq_oe_n),
    .irq_pin(irq_pin));

  misc_regs uut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .powerup_in_progress(lvl[0]),
    .powerdown_in_progress(lvl[1]), .power_button_input(lvl[2]), .low_rail_level(lvl[3]),
    .rail_overvolt_level(lvl[4]), .fuse_run_code(fuse_code), .fuse_run_enable(fuse_en),
    .power_mode(power_mode), .irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n),
    .coin_charge_voltage(cvolt), .coin_charge_enable(cen), .buck_one_code(bcode),
    .buck_one_run_enable(ben));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rreg(input logic [7:0] idx, input logic [31:0] exp, input string name);
    host.xfer(idx, 1'b0, 32'h0, rd);
    check(name, rd, exp);
  endtask : rreg

  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(idx, 1'b1, d, rd);
  endtask : wreg

  // Level i goes high for two cycles then low, which raises the event of source i once, or twice for the button (each edge).
  task automatic pulse(input int i);
    @(posedge mclk);
    lvl <= 5'(1 << i);
    repeat (2) @(posedge mclk);
    lvl <= 5'h0;
    repeat (3) @(posedge mclk);
  endtask : pulse

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    lvl = 5'h0;
    power_mode = MODE_RUN;
    rng = xs(32'd26764);
    fuse_code = rng[5:0];
    fuse_en = rng[6];
    bidx = '{IDX_BUCK_ONE_RUN_VOLTAGE, IDX_BUCK_ONE_STANDBY_VOLTAGE, IDX_BUCK_ONE_SLEEP_VOLTAGE};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rreg(IDX_MISC_IRQ_MASK, 32'h1f, "mask");
    rreg(IDX_MISC_IRQ_SENSE, 32'h0, "sense");
    rreg(IDX_COIN_CHARGER_CONTROL, 32'h0, "coin");
    for (int k = 0; k < 3; k++) rreg(bidx[k], {26'h0, fuse_code}, "code");
    rreg(IDX_BUCK_ONE_CONTROL, {31'h0, fuse_en}, "enable");
    check("hresp", {31'h0, hresp}, 32'h0);
    wreg(IDX_MISC_IRQ_SENSE, 32'h1f);
    rreg(IDX_MISC_IRQ_SENSE, 32'h0, "sense write");
    wreg(8'h31, 32'hff);
    rreg(8'h31, 32'h0, "unmapped");
    rng = xs(rng);
    wreg(IDX_COIN_CHARGER_CONTROL, rng);
    rreg(IDX_COIN_CHARGER_CONTROL, {27'h0, rng[4:0]}, "coin");
    check("coin out", {27'h0, cen, cvolt}, {27'h0, rng[4:0]});
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      codes[k] = rng[5:0];
      wreg(bidx[k], rng);
      rreg(bidx[k], {26'h0, codes[k]}, "code");
    end
    for (int k = 0; k < 3; k++) begin
      power_mode <= power_mode_t'(k);
      repeat (3) @(posedge mclk);
      check("buck code", {26'h0, bcode}, {26'h0, codes[k]});
    end
    wreg(IDX_BUCK_ONE_CONTROL, 32'h0);
    rreg(IDX_BUCK_ONE_CONTROL, 32'h0, "enable");
    check("enable out", {31'h0, ben}, 32'h0);
    rng = xs(rng);
    r5 = rng[4:0];
    lvl <= r5;
    repeat (3) @(posedge mclk);
    rreg(IDX_MISC_IRQ_SENSE, {27'h0, r5}, "sense");
    lvl <= 5'h0;
    repeat (3) @(posedge mclk);
    check("masked pin", {31'h0, irq_pin}, 32'h1);
    rreg(IDX_MISC_IRQ_STATUS, {27'h0, r5}, "status");
    rreg(IDX_MISC_IRQ_STATUS, 32'h0, "status");
    for (int i = 0; i < 5; i++) begin
      wreg(IDX_MISC_IRQ_MASK, 32'h1f & ~(32'h1 << i));
      pulse(i);
      check("pin", {30'h0, irq_out_n, irq_pin}, 32'h0);
      wreg(IDX_MISC_IRQ_STATUS, 32'h1 << i);
      @(posedge mclk);
      check("pin", {31'h0, irq_pin}, 32'h1);
      rreg(IDX_MISC_IRQ_STATUS, 32'h0, "status");
      wreg(IDX_MISC_IRQ_MASK, 32'h1f);
      pulse(i);
      check("pin", {31'h0, irq_pin}, 32'h1);
      rreg(IDX_MISC_IRQ_STATUS, 32'h1 << i, "status");
    end
    wreg(IDX_MISC_IRQ_MASK, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rreg(IDX_MISC_IRQ_MASK, 32'h1f, "mask");
    end_of_test();
  end
endmodule : tb_top
